// *** link_irq_pkg.sv ***
// Constants, types and register map of the link interrupt register group
//
// Functional notes
// - Eight-bit mask, reset zero, gates status bits.
// - Status bits clear on write one only.
// - Bit 7 sets on port 1/2 analog change.
// - Bit 2 sets on port 3 change.
// - Bit 1 sets on port 2 analog change.
// - Bit 0 sets on port 1 change.
// - Enabled pause-off limit requests invalidation after 160ms.
// - Regulator control bit 6 disables internal regulator.
// - Six bits enable default tag insertion per path.
package link_irq_pkg;

  // ******************************************************************
  // Register map
  // ******************************************************************
  localparam logic [7:0] IRQ_MASK_ADDR    = 8'hbb;
  localparam logic [7:0] LINK_STATUS_ADDR = 8'hbc;
  localparam logic [7:0] PAUSE_LIMIT_ADDR = 8'hbd;
  localparam logic [7:0] FIBER_THR_ADDR   = 8'hc0;
  localparam logic [7:0] REGULATOR_ADDR   = 8'hc1;
  localparam logic [7:0] VLAN_INS_ADDR    = 8'hc2;

  // ******************************************************************
  // Field layout and reset values
  // ******************************************************************
  localparam int         ST_P12_BIT       = 7;
  localparam int         ST_P3_BIT        = 2;
  localparam int         ST_P2_BIT        = 1;
  localparam int         ST_P1_BIT        = 0;
  localparam logic [7:0] STATUS_USED_MASK = 8'h87;
  localparam logic [7:0] FIBER_USED_MASK  = 8'hc0;
  localparam logic [7:0] REG_USED_MASK    = 8'h40;
  localparam logic [7:0] VLAN_USED_MASK   = 8'h3f;
  localparam logic [7:0] REG_RESET        = 8'h00;

  // ******************************************************************
  // Timing
  // ******************************************************************
  localparam int CLK_PERIOD_NS  = 100;
  localparam int PAUSE_LIMIT_MS = 160;
  localparam int PAUSE_LIMIT_CYC =
    (PAUSE_LIMIT_MS * 1000000) / CLK_PERIOD_NS;
  localparam int PCNT_W = 21;

  // ******************************************************************
  // Carriers
  // ******************************************************************
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_s;

  typedef struct packed {
    logic p1_analog;
    logic p1_mii;
    logic p2_analog;
    logic p3_mii;
  } link_events_s;

  typedef enum logic [1:0] {
    PAUSE_IDLE  = 2'b00,
    PAUSE_COUNT = 2'b01,
    PAUSE_DONE  = 2'b11
  } pause_state_e;

  typedef struct packed {
    logic [7:0]        mask;
    logic [7:0]        status;
    logic [7:0]        pause_en;
    logic [7:0]        fiber;
    logic [7:0]        regulator;
    logic [7:0]        vlan;
    logic [7:0]        rdata;
    pause_state_e      pstate;
    logic [PCNT_W-1:0] pcnt;
    logic              invalidate;
  } state_s;

endpackage : link_irq_pkg

// *** link_irq_regs.sv ***
// Link interrupt, pause limit and misc control register group
module link_irq_regs
  import link_irq_pkg::*;
(
  input  wire logic         clk_i,
  input  wire logic         reset_i,
  input  wire reg_req_s     req_i,
  input  wire link_events_s link_ev_i,
  input  wire logic         pause_active_i,
  output logic [7:0]        rdata_o,
  output logic              link_irq_out_n,
  output logic              pause_invalidate_o,
  output logic              p2_fiber_thr_high_o,
  output logic              p1_fiber_thr_high_o,
  output logic              regulator_disable_o,
  output logic [5:0]        ingress_origin_insert_o
);

  state_s st_r;
  state_s st_nxt;
  logic [7:0] set_vec;

  // ******************************************************************
  // Check defaults
  // ******************************************************************
  // One clock domain, so every check shares one clock and reset guard
  default clocking chk_cb @(posedge clk_i);
  endclocking
  default disable iff (reset_i);

  // ******************************************************************
  // Read decode
  // ******************************************************************
  // Unmapped addresses read zero so a probe of a hole is harmless
  function automatic logic [7:0] read_mux(input state_s     s,
                                          input logic [7:0] a);
    logic [7:0] v;
    case (a)
      IRQ_MASK_ADDR:    v = s.mask;
      LINK_STATUS_ADDR: v = s.status;
      PAUSE_LIMIT_ADDR: v = s.pause_en;
      FIBER_THR_ADDR:   v = s.fiber;
      REGULATOR_ADDR:   v = s.regulator;
      VLAN_INS_ADDR:    v = s.vlan;
      default:          v = 8'h00;
    endcase
    return v;
  endfunction

  // ******************************************************************
  // Next state
  // ******************************************************************
  // Set bits are ORed after the clear so a same-cycle event wins
  always_comb
  begin
    set_vec = 8'h00;
    set_vec[ST_P12_BIT] = link_ev_i.p1_analog | link_ev_i.p2_analog;
    set_vec[ST_P3_BIT]  = link_ev_i.p3_mii;
    set_vec[ST_P2_BIT]  = link_ev_i.p2_analog;
    set_vec[ST_P1_BIT]  = link_ev_i.p1_analog | link_ev_i.p1_mii;
    st_nxt = st_r;
    st_nxt.invalidate = 1'b0;
    if (req_i.wr)
    begin
      case (req_i.addr)
        IRQ_MASK_ADDR:
          st_nxt.mask = req_i.wdata;
        LINK_STATUS_ADDR:
          st_nxt.status = st_r.status & ~req_i.wdata;
        PAUSE_LIMIT_ADDR:
          st_nxt.pause_en = req_i.wdata;
        FIBER_THR_ADDR:
          st_nxt.fiber = req_i.wdata & FIBER_USED_MASK;
        REGULATOR_ADDR:
          st_nxt.regulator = req_i.wdata & REG_USED_MASK;
        VLAN_INS_ADDR:
          st_nxt.vlan = req_i.wdata & VLAN_USED_MASK;
        default:
          st_nxt.mask = st_r.mask;
      endcase
    end
    // Reserved status bits can never be set, so they always read zero
    st_nxt.status = st_nxt.status | (set_vec & STATUS_USED_MASK);

    // Read data registered; it holds until the next read strobe
    if (req_i.rd)
      st_nxt.rdata = read_mux(st_r, req_i.addr);

    // Pause limit timer: restarts whenever pause drops or enable clears
    case (st_r.pstate)
      PAUSE_IDLE:
      begin
        st_nxt.pcnt = '0;
        if (st_r.pause_en[0] && pause_active_i)
          st_nxt.pstate = PAUSE_COUNT;
      end
      PAUSE_COUNT:
      begin
        if (!st_r.pause_en[0] || !pause_active_i)
          st_nxt.pstate = PAUSE_IDLE;
        else if (st_r.pcnt == PCNT_W'(PAUSE_LIMIT_CYC - 2))
        begin
          st_nxt.invalidate = 1'b1;
          st_nxt.pstate = PAUSE_DONE;
        end
        else
          st_nxt.pcnt = st_r.pcnt + PCNT_W'(1);
      end
      PAUSE_DONE:
      begin
        // One request per pause episode
        if (!st_r.pause_en[0] || !pause_active_i)
          st_nxt.pstate = PAUSE_IDLE;
      end
      default: st_nxt.pstate = PAUSE_IDLE;
    endcase
  end

  // ******************************************************************
  // State register
  // ******************************************************************
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      st_r <= '0;
      st_r.mask <= REG_RESET;
    end
    else
      st_r <= st_nxt;
  end

  // Outputs
  assign rdata_o                 = st_r.rdata;
  assign link_irq_out_n          = ~|(st_r.status & st_r.mask);
  assign pause_invalidate_o      = st_r.invalidate;
  assign p2_fiber_thr_high_o     = st_r.fiber[7];
  assign p1_fiber_thr_high_o     = st_r.fiber[6];
  assign regulator_disable_o     = st_r.regulator[6];
  assign ingress_origin_insert_o = st_r.vlan[5:0];

  // ******************************************************************
  // Checks
  // ******************************************************************
  // Status clearing: a one clears, a zero keeps, an event beats a clear
  chk_status_w1c: assert property (
    (req_i.wr && req_i.addr == LINK_STATUS_ADDR
     && req_i.wdata[ST_P3_BIT] && !link_ev_i.p3_mii)
    |=> !st_r.status[ST_P3_BIT])
    else $error("status bit not cleared by write one");
  chk_status_keep: assert property (
    (req_i.wr && req_i.addr == LINK_STATUS_ADDR
     && req_i.wdata == 8'h00 && link_ev_i == '0)
    |=> st_r.status == $past(st_r.status))
    else $error("zero write changed status");
  chk_set_wins: assert property (
    (req_i.wr && req_i.addr == LINK_STATUS_ADDR
     && req_i.wdata[ST_P2_BIT] && link_ev_i.p2_analog)
    |=> st_r.status[ST_P2_BIT])
    else $error("event lost to same cycle clear");
  chk_status_rsvd: assert property (
    (st_r.status & ~STATUS_USED_MASK) == 8'h00)
    else $error("reserved status bit set");

  // Event sources into their status bits
  chk_p12_set: assert property (
    (link_ev_i.p1_analog || link_ev_i.p2_analog)
    |=> st_r.status[ST_P12_BIT])
    else $error("bit 7 not set");
  chk_p3_set: assert property (
    link_ev_i.p3_mii |=> st_r.status[ST_P3_BIT])
    else $error("bit 2 not set");
  chk_p2_set: assert property (
    link_ev_i.p2_analog |=> st_r.status[ST_P2_BIT])
    else $error("bit 1 not set");
  chk_p1_set: assert property (
    (link_ev_i.p1_analog || link_ev_i.p1_mii)
    |=> st_r.status[ST_P1_BIT])
    else $error("bit 0 not set");

  // Mask and interrupt pin
  chk_mask_write: assert property (
    (req_i.wr && req_i.addr == IRQ_MASK_ADDR)
    |=> st_r.mask == $past(req_i.wdata))
    else $error("mask write lost");
  chk_irq_level: assert property (
    (st_r.status[ST_P2_BIT] && st_r.mask[ST_P2_BIT]) |-> !link_irq_out_n)
    else $error("interrupt not asserted");
  chk_irq_release: assert property (
    (st_r.status & st_r.mask) == 8'h00 |-> link_irq_out_n)
    else $error("interrupt low with nothing enabled");

  // Pause limit timer
  chk_pause_off: assert property (
    !st_r.pause_en[0] |=> !pause_invalidate_o)
    else $error("invalidate while disabled");
  chk_pause_drop: assert property (
    !pause_active_i |=> !pause_invalidate_o)
    else $error("invalidate without pause");
  chk_pause_step: assert property (
    (st_r.pstate == PAUSE_COUNT && st_r.pause_en[0] && pause_active_i)
    |=> (st_r.pcnt == $past(st_r.pcnt) + PCNT_W'(1)) || pause_invalidate_o)
    else $error("pause timer did not advance");
  chk_pause_limit: assert property (
    pause_invalidate_o |-> st_r.pcnt == PCNT_W'(PAUSE_LIMIT_CYC - 2))
    else $error("invalidate before the full limit");
  chk_pause_pulse: assert property (
    pause_invalidate_o |=> !pause_invalidate_o)
    else $error("invalidate longer than one cycle");

  // Control outputs follow their writes
  chk_reg_bit: assert property (
    (req_i.wr && req_i.addr == REGULATOR_ADDR)
    |=> regulator_disable_o == $past(req_i.wdata[6]))
    else $error("regulator bit wrong");
  chk_fiber_write: assert property (
    (req_i.wr && req_i.addr == FIBER_THR_ADDR)
    |=> {p2_fiber_thr_high_o, p1_fiber_thr_high_o}
        == $past(req_i.wdata[7:6]))
    else $error("fiber threshold bits wrong");
  chk_vlan_write: assert property (
    (req_i.wr && req_i.addr == VLAN_INS_ADDR)
    |=> ingress_origin_insert_o == $past(req_i.wdata[5:0]))
    else $error("tag insertion bits wrong");

  // Read port: data of the strobed register, then held
  chk_read_status: assert property (
    (req_i.rd && req_i.addr == LINK_STATUS_ADDR)
    |=> rdata_o == $past(st_r.status))
    else $error("status read data wrong");
  chk_rdata_hold: assert property (
    !req_i.rd |=> $stable(rdata_o))
    else $error("read data moved without a read");

  cov_irq: cover property (
    $fell(link_irq_out_n));
  cov_clear: cover property (
    $rose(link_irq_out_n));
  cov_inval: cover property (
    pause_invalidate_o);
  cov_set_wins: cover property (
    req_i.wr && req_i.addr == LINK_STATUS_ADDR
    && req_i.wdata[ST_P2_BIT] && link_ev_i.p2_analog);
  cov_pause_count: cover property (
    st_r.pstate == PAUSE_COUNT && st_r.pcnt == PCNT_W'(1000));

endmodule // link_irq_regs

// *** tb_link_irq_regs.sv ***
// Self-checking testbench for the link interrupt register group
module tb_link_irq_regs;
  timeunit 1ns;
  timeprecision 1ns;
  import link_irq_pkg::*;

  // ******************************************************************
  // Signals
  // ******************************************************************
  logic         clk_i, reset_i, pause_active_i;
  logic         rd_seen = 1'b0;
  reg_req_s     req_i;
  link_events_s link_ev_i;
  logic [7:0]   rdata_o, d, expv;
  logic [5:0]   ingress_origin_insert_o;
  logic         link_irq_out_n, pause_invalidate_o;
  logic         p2_fiber_thr_high_o, p1_fiber_thr_high_o;
  logic         regulator_disable_o;
  logic [31:0]  seed = 32'h7fcbc849;
  logic [7:0]   exp_q[$];
  logic [7:0]   st[4] = '{8'h81, 8'h01, 8'h82, 8'h04};
  logic [7:0]   addrs[6] = '{IRQ_MASK_ADDR, LINK_STATUS_ADDR,
    PAUSE_LIMIT_ADDR, FIBER_THR_ADDR, REGULATOR_ADDR, VLAN_INS_ADDR};
  logic [7:0]   msk[6] = '{8'hff, 8'h00, 8'hff, FIBER_USED_MASK,
    REG_USED_MASK, VLAN_USED_MASK};
  int           error_cnt = 0, n_tests = 0, cyc = 0;

  link_irq_regs DUT (.clk_i(clk_i), .reset_i(reset_i), .req_i(req_i),
    .link_ev_i(link_ev_i), .pause_active_i(pause_active_i),
    .rdata_o(rdata_o), .link_irq_out_n(link_irq_out_n),
    .pause_invalidate_o(pause_invalidate_o),
    .p2_fiber_thr_high_o(p2_fiber_thr_high_o),
    .p1_fiber_thr_high_o(p1_fiber_thr_high_o),
    .regulator_disable_o(regulator_disable_o),
    .ingress_origin_insert_o(ingress_origin_insert_o));

  // ******************************************************************
  // Helpers
  // ******************************************************************
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic chk(input logic ok, input string msg);
    n_tests++;
    if (ok !== 1'b1)
    begin
      error_cnt++;
      $display("mismatch %0t %s", $time, msg);
    end
  endtask
  task automatic summarize();
    if (error_cnt == 0 && n_tests > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // One bus cycle per call; back-to-back calls keep one change per edge
  task automatic acc(input logic w, input logic r, input logic [7:0] a,
                     input logic [7:0] wd);
    @(negedge clk_i);
    req_i = '{wr: w, rd: r, addr: a, wdata: wd};
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    acc(1'b0, 1'b1, a, 8'h00);
  endtask
  task automatic idle();
    @(negedge clk_i);
    req_i = '0;
  endtask

  // ******************************************************************
  // Clock, timeout and read watcher
  // ******************************************************************
  initial
  begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end
  // Generous ceiling: the sequence needs about two thousand cycles
  always @(posedge clk_i)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      error_cnt++;
      $display("mismatch %0t timeout", $time);
      summarize();
    end
  end
  always @(posedge clk_i) rd_seen <= req_i.rd;
  // Read data lands one cycle after the strobe; compare the oldest note
  always @(negedge clk_i)
    if (rd_seen)
    begin
      chk(exp_q.size() > 0 && rdata_o === exp_q[0], "read data");
      if (exp_q.size() > 0) void'(exp_q.pop_front());
    end

  // ******************************************************************
  // Main sequence
  // ******************************************************************
  initial
  begin
    reset_i = 1'b1; req_i = '0; link_ev_i = '0; pause_active_i = 1'b0;
    repeat (16) @(negedge clk_i);
    reset_i = 1'b0;
    // Reset values, then an unmapped address
    for (int i = 0; i < 6; i++) rd(addrs[i], 8'h00);
    rd(8'hbe, 8'h00);
    chk(link_irq_out_n === 1'b1, "irq at reset");
    // Random write then back-to-back read; reserved bits read as zero
    for (int i = 0; i < 6; i++)
    begin
      seed = lfsr(seed);
      d = seed[7:0];
      // Status bits 6..3 must only ever be written as zero
      if (addrs[i] == LINK_STATUS_ADDR) d = d & STATUS_USED_MASK;
      expv = d & msk[i];
      acc(1'b1, 1'b0, addrs[i], d);
      rd(addrs[i], expv);
      if (i == 3)
      begin
        chk(p2_fiber_thr_high_o === expv[7], "fiber p2");
        chk(p1_fiber_thr_high_o === expv[6], "fiber p1");
      end
      if (i == 4)
        chk(regulator_disable_o === expv[6], "regulator");
      if (i == 5)
        chk(ingress_origin_insert_o === expv[5:0], "vlan");
    end
    acc(1'b1, 1'b0, 8'hbe, 8'hff);
    rd(8'hbe, 8'h00);
    // Each event kind: mask first, clear, then wait for the interrupt
    for (int i = 0; i < 4; i++)
    begin
      acc(1'b1, 1'b0, IRQ_MASK_ADDR, st[i]);
      acc(1'b1, 1'b0, LINK_STATUS_ADDR, STATUS_USED_MASK);
      @(negedge clk_i);
      req_i = '0;
      link_ev_i = link_events_s'(4'b1000 >> i);
      @(negedge clk_i);
      link_ev_i = '0;
      chk(link_irq_out_n === 1'b0, "irq low");
      rd(LINK_STATUS_ADDR, st[i]);
      acc(1'b1, 1'b0, LINK_STATUS_ADDR, 8'h00);
      rd(LINK_STATUS_ADDR, st[i]);
      acc(1'b1, 1'b0, IRQ_MASK_ADDR, ~st[i]);
      idle();
      chk(link_irq_out_n === 1'b1, "irq masked");
      acc(1'b1, 1'b0, LINK_STATUS_ADDR, st[i]);
      rd(LINK_STATUS_ADDR, 8'h00);
    end
    // An event in the clearing cycle survives the clear
    acc(1'b1, 1'b0, LINK_STATUS_ADDR, STATUS_USED_MASK);
    link_ev_i.p2_analog = 1'b1;
    idle();
    link_ev_i = '0;
    chk(link_irq_out_n === 1'b0, "set lost to clear");
    rd(LINK_STATUS_ADDR, 8'h82);
    acc(1'b1, 1'b0, LINK_STATUS_ADDR, 8'h82);
    rd(LINK_STATUS_ADDR, 8'h00);
    idle();
    // Mid-run reset returns mask and controls to zero
    reset_i = 1'b1;
    repeat (2) @(negedge clk_i);
    reset_i = 1'b0;
    rd(IRQ_MASK_ADDR, 8'h00);
    rd(VLAN_INS_ADDR, 8'h00);
    chk(link_irq_out_n === 1'b1, "irq after reset");
    // The full 160 ms is too long to run; check nothing fires early
    acc(1'b1, 1'b0, PAUSE_LIMIT_ADDR, 8'h01);
    idle();
    pause_active_i = 1'b1;
    repeat (2000)
    begin
      @(negedge clk_i);
      chk(pause_invalidate_o === 1'b0, "early invalidate");
    end
    pause_active_i = 1'b0;
    repeat (3) @(negedge clk_i);
    summarize();
  end
endmodule // tb_link_irq_regs
